/* rtl/ptw_pkg.sv */
// shared types and constants for the pci target window decode
package ptw_pkg;

   // ****************************************************
   // window geometry
   // ****************************************************
   localparam int NUM_WIN = 4;
   localparam int DAC_WIN = 3;
   localparam logic [2:0] PASS_WIN = 3'h4;
   localparam int ADDR_W = 64;
   localparam int PHYS_W = 34;
   localparam int MASK_LSB = 20;
   localparam int MASK_MSB = 31;
   localparam int MASK_W = 12;
   localparam int SAC_MSB = 31;
   localparam int DAC_LSB = 32;
   localparam int DAC_MSB = 39;
   localparam int DAC_W = 8;
   localparam int DAC_ZERO_LSB = 40;
   localparam int TB_W = 14;
   // cached memory is 8GB: bits above 32 of a memory address are zero
   localparam int MEM_MSB = 32;

   // ****************************************************
   // fixed patterns
   // ****************************************************
   localparam logic [19:0] PAGE_ONES = 20'hf_ffff;
   localparam logic [19:0] PAGE_ZERO = 20'h0_0000;
   localparam logic [1:0] TOP_ZERO = 2'h0;
   localparam logic [11:0] MASK_1MB = 12'h000;
   localparam logic [11:0] MASK_4GB = 12'hfff;
   localparam logic [11:0] MASK_ONE = 12'h001;

   // ****************************************************
   // carriers
   // ****************************************************
   typedef struct packed {
      logic enable;
      logic sgTranslationSelect;
      logic dacEnable;
      logic [MASK_W-1:0] base;
      logic [MASK_W-1:0] sizeMask;
      logic [TB_W-1:0] transBase;
   } ptw_win_cfg_t;

   typedef struct packed {
      logic valid;
      logic dac;
      logic [ADDR_W-1:0] addr;
   } ptw_req_t;

   typedef struct packed {
      logic claim;
      logic [2:0] window;
      logic sgTranslationSelect;
      logic [PHYS_W-1:0] physAddr;
   } ptw_result_t;

endpackage

/* rtl/ptw_window_decode.sv */
// inbound pci memory address decode against the target windows
`timescale 1ns/1ps

// Summary of operation
// - map pci addresses into 8GB cached memory
// - window 4 passes dac address bits 33:0
// - windows 0-3 own base, mask, translated base
// - window 3 has extra dac upper base
// - mask covers bits 31:20, 1MB to 4GB
// - mask is contiguous ones from bit 20
// - compare only bits 31 down to n
// - hit when unmasked bits equal the base
// - per-window enable bit, 1 enables
// - claim cycle on hit of enabled window
// - no base/limit, whole window responds
// - each of windows 0-3 selects direct or scatter-gather
// - upper compare only window 3 in dac
// - windows 0-2 take single-address cycles only
// - dac hit needs 63:40 zero, 39:32 match
// - matched address becomes 34-bit physical address
// - direct: translated base above n, address below
module ptw_window_decode #(
   parameter int NUM_WIN = ptw_pkg::NUM_WIN
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire ptw_pkg::ptw_win_cfg_t [NUM_WIN-1:0] winCfg,
   input wire logic [ptw_pkg::DAC_W-1:0] dacBase,
   input wire logic passEnable,
   input wire ptw_pkg::ptw_req_t req,
   output ptw_pkg::ptw_result_t result,
   output logic [NUM_WIN-1:0] maskLegal
);

   // ****************************************************
   // address fields
   // ****************************************************
   logic [ptw_pkg::SAC_MSB:0] loAddr;
   logic dacUpperOk;
   logic passHit;
   logic [NUM_WIN-1:0] winHit;
   logic [NUM_WIN-1:0][ptw_pkg::PHYS_W-1:0] winPhys;
   ptw_pkg::ptw_result_t next_result;
   logic [NUM_WIN-1:0] next_maskLegal;

   assign loAddr = req.addr[ptw_pkg::SAC_MSB:0];

   // upper half of a dual-address cycle against the window 3 extra base
   assign dacUpperOk =
      (req.addr[ptw_pkg::ADDR_W-1:ptw_pkg::DAC_ZERO_LSB] == '0) &&
      (req.addr[ptw_pkg::DAC_MSB:ptw_pkg::DAC_LSB] == dacBase);

   // fixed pass-through window, only inside cached memory
   assign passHit = req.valid && req.dac && passEnable &&
      (req.addr[ptw_pkg::ADDR_W-1:ptw_pkg::MEM_MSB+1] == '0);

   // ****************************************************
   // per-window compare and direct translation
   // ****************************************************
   for (genvar w = 0; w < NUM_WIN; w++) begin : g_win
      logic [ptw_pkg::MASK_W-1:0] diff;
      logic baseMatch;
      logic cycleOk;
      logic [ptw_pkg::PHYS_W-1:0] lowSel;
      logic [ptw_pkg::MASK_W-1:0] maskPlus;

      // mask ones drop address bits from the compare
      assign diff = (loAddr[ptw_pkg::MASK_MSB:ptw_pkg::MASK_LSB] ^ winCfg[w].base) &
         ~winCfg[w].sizeMask;
      assign baseMatch = (diff == '0);

      if (w == ptw_pkg::DAC_WIN) begin : g_dac
         assign cycleOk = winCfg[w].dacEnable ?
            (req.dac && dacUpperOk) : !req.dac;
      end else begin : g_sac
         assign cycleOk = !req.dac;
      end

      // no base/limit: any address inside an enabled window hits
      assign winHit[w] = req.valid && winCfg[w].enable &&
         baseMatch && cycleOk;

      // and-or concatenation: low bits from pci, high from translated base
      assign lowSel = {ptw_pkg::TOP_ZERO, winCfg[w].sizeMask, ptw_pkg::PAGE_ONES};
      assign winPhys[w] = ({ptw_pkg::TOP_ZERO, loAddr} & lowSel) |
         {winCfg[w].transBase, ptw_pkg::PAGE_ZERO};

      // legal mask is a run of ones from bit 20: m & (m + 1) == 0
      assign maskPlus = winCfg[w].sizeMask + ptw_pkg::MASK_ONE;
      assign next_maskLegal[w] = ((winCfg[w].sizeMask & maskPlus) == '0);
   end

   // ****************************************************
   // priority select and result
   // ****************************************************
   // overlapping windows are a software error; lowest index wins
   always_comb begin
      next_result = '0;
      if (passHit) begin
         next_result.claim = 1'b1;
         next_result.window = ptw_pkg::PASS_WIN;
         next_result.physAddr = req.addr[ptw_pkg::PHYS_W-1:0];
      end
      for (int w = NUM_WIN - 1; w >= 0; w--) begin
         if (winHit[w]) begin
            next_result.claim = 1'b1;
            next_result.window = 3'(w);
            next_result.sgTranslationSelect = winCfg[w].sgTranslationSelect;
            // scatter-gather walks the map from the translated base
            next_result.physAddr = winCfg[w].sgTranslationSelect ?
               {winCfg[w].transBase, ptw_pkg::PAGE_ZERO} : winPhys[w];
         end
      end
   end

   // a miss everywhere leaves claim low
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         result <= '0;
      end else begin
         result <= next_result;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         maskLegal <= '0;
      end else begin
         maskLegal <= next_maskLegal;
      end
   end

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   sequence s_anyHit;
      req.valid && (|winHit);
   endsequence

   sequence s_quiet;
      !req.valid;
   endsequence

   property p_claim_on_hit;
      s_anyHit |=> result.claim;
   endproperty
   a_claim_on_hit: assert property (p_claim_on_hit)
      else $error("enabled window hit not claimed");

   property p_no_claim_on_miss;
      (req.valid && !(|winHit) && !passHit) |=> !result.claim;
   endproperty
   a_no_claim_on_miss: assert property (p_no_claim_on_miss)
      else $error("cycle claimed on a miss");

   property p_claim_one_cycle;
      s_anyHit ##1 s_quiet |=> !result.claim;
   endproperty
   a_claim_one_cycle: assert property (p_claim_one_cycle)
      else $error("claim held past its request");

   property p_sac_windows;
      result.claim && (result.window != 3'(ptw_pkg::DAC_WIN)) &&
         (result.window != ptw_pkg::PASS_WIN) |-> !$past(req.dac);
   endproperty
   a_sac_windows: assert property (p_sac_windows)
      else $error("single-address window took a dac cycle");

   property p_dac_window3;
      result.claim && (result.window == 3'(ptw_pkg::DAC_WIN)) && $past(req.dac) |->
         ($past(req.addr[ptw_pkg::ADDR_W-1:ptw_pkg::DAC_ZERO_LSB]) == '0) &&
         ($past(req.addr[ptw_pkg::DAC_MSB:ptw_pkg::DAC_LSB]) == $past(dacBase)) &&
         $past(winCfg[ptw_pkg::DAC_WIN].dacEnable);
   endproperty
   a_dac_window3: assert property (p_dac_window3)
      else $error("window 3 dac hit with bad upper address");

   property p_pass_thru;
      result.claim && (result.window == ptw_pkg::PASS_WIN) |->
         $past(req.dac) && (result.physAddr == $past(req.addr[ptw_pkg::PHYS_W-1:0]));
   endproperty
   a_pass_thru: assert property (p_pass_thru)
      else $error("pass-through window altered the address");

   property p_direct_low;
      result.claim && (result.window != ptw_pkg::PASS_WIN) &&
         !result.sgTranslationSelect |->
         result.physAddr[ptw_pkg::MASK_LSB-1:0] ==
         $past(req.addr[ptw_pkg::MASK_LSB-1:0]);
   endproperty
   a_direct_low: assert property (p_direct_low)
      else $error("direct translation lost page offset bits");

   property p_whole_4gb;
      req.valid && !req.dac && winCfg[0].enable &&
         (winCfg[0].sizeMask == ptw_pkg::MASK_4GB) |=> result.claim;
   endproperty
   a_whole_4gb: assert property (p_whole_4gb)
      else $error("4GB window missed an address");

   property p_mask_1mb_legal;
      (winCfg[0].sizeMask == ptw_pkg::MASK_1MB) |=> maskLegal[0];
   endproperty
   a_mask_1mb_legal: assert property (p_mask_1mb_legal)
      else $error("1MB mask reported illegal");

   property p_phys_in_memory;
      result.claim && (result.window == ptw_pkg::PASS_WIN) |->
         !result.physAddr[ptw_pkg::PHYS_W-1];
   endproperty
   a_phys_in_memory: assert property (p_phys_in_memory)
      else $error("pass-through address beyond cached memory");

   // ****************************************************
   // claim framing
   // ****************************************************
   sequence s_claimed;
      result.claim;
   endsequence

   sequence s_passClaim;
      result.claim && (result.window == ptw_pkg::PASS_WIN);
   endsequence

   property p_claim_needs_request;
      s_claimed |-> $past(req.valid);
   endproperty
   a_claim_needs_request: assert property (p_claim_needs_request)
      else $error("claim without a request");

   property p_miss_clean;
      !result.claim |-> (result.window == '0) && (result.physAddr == '0) &&
         !result.sgTranslationSelect;
   endproperty
   a_miss_clean: assert property (p_miss_clean)
      else $error("unclaimed result carries stale fields");

   // ****************************************************
   // dual-address and pass-through
   // ****************************************************
   // numbered windows always shadow the pass-through window
   property p_pass_gate;
      s_passClaim |-> $past(passEnable) && ($past(winHit) == '0);
   endproperty
   a_pass_gate: assert property (p_pass_gate)
      else $error("pass-through window claimed while off or shadowed");

   property p_pass_range;
      s_passClaim |-> ($past(req.addr[ptw_pkg::ADDR_W-1:ptw_pkg::MEM_MSB+1]) == '0);
   endproperty
   a_pass_range: assert property (p_pass_range)
      else $error("pass-through claimed above cached memory");

   property p_pass_taken;
      (req.valid && req.dac && passEnable && !(|winHit) &&
         (req.addr[ptw_pkg::ADDR_W-1:ptw_pkg::MEM_MSB+1] == '0)) |=> s_passClaim;
   endproperty
   a_pass_taken: assert property (p_pass_taken)
      else $error("pass-through address not claimed");

   property p_dac_only;
      result.claim && (result.window == 3'(ptw_pkg::DAC_WIN)) &&
         $past(winCfg[ptw_pkg::DAC_WIN].dacEnable) |-> $past(req.dac);
   endproperty
   a_dac_only: assert property (p_dac_only)
      else $error("dac window 3 took a single-address cycle");

   property p_dac_upper_zero;
      s_claimed ##0 $past(req.dac) |->
         ($past(req.addr[ptw_pkg::ADDR_W-1:ptw_pkg::DAC_ZERO_LSB]) == '0);
   endproperty
   a_dac_upper_zero: assert property (p_dac_upper_zero)
      else $error("dac claim with nonzero top address bits");

   // ****************************************************
   // per-window checks
   // ****************************************************
   for (genvar w = 0; w < NUM_WIN; w++) begin : g_chk
      property p_win_enable;
         result.claim && (result.window == 3'(w)) |-> $past(winCfg[w].enable);
      endproperty
      a_win_enable: assert property (p_win_enable)
         else $error("disabled window claimed a cycle");

      property p_win_mode;
         result.claim && (result.window == 3'(w)) |->
            result.sgTranslationSelect == $past(winCfg[w].sgTranslationSelect);
      endproperty
      a_win_mode: assert property (p_win_mode)
         else $error("translation mode does not follow window");

      property p_win_base;
         result.claim && (result.window == 3'(w)) |->
            (($past(loAddr[ptw_pkg::MASK_MSB:ptw_pkg::MASK_LSB]) ^
            $past(winCfg[w].base)) & ~$past(winCfg[w].sizeMask)) == '0;
      endproperty
      a_win_base: assert property (p_win_base)
         else $error("hit declared with unequal base bits");

      property p_win_claim;
         req.valid && winHit[w] |=> result.claim && (result.window <= 3'(w));
      endproperty
      a_win_claim: assert property (p_win_claim)
         else $error("window hit not reported");

      property p_win_off;
         req.valid && !winCfg[w].enable |=> !(result.claim && (result.window == 3'(w)));
      endproperty
      a_win_off: assert property (p_win_off)
         else $error("disabled window answered a request");

      property p_sg_base;
         result.claim && (result.window == 3'(w)) && result.sgTranslationSelect |->
            result.physAddr == {$past(winCfg[w].transBase), ptw_pkg::PAGE_ZERO};
      endproperty
      a_sg_base: assert property (p_sg_base)
         else $error("scatter-gather start not taken from translated base");

      property p_direct_high;
         result.claim && (result.window == 3'(w)) && !result.sgTranslationSelect |->
            result.physAddr[ptw_pkg::PHYS_W-1:ptw_pkg::MASK_LSB] ==
            ($past(winCfg[w].transBase) |
            ({ptw_pkg::TOP_ZERO, $past(loAddr[ptw_pkg::MASK_MSB:ptw_pkg::MASK_LSB])} &
            {ptw_pkg::TOP_ZERO, $past(winCfg[w].sizeMask)}));
      endproperty
      a_direct_high: assert property (p_direct_high)
         else $error("direct translation upper bits wrong");

      property p_mask_4gb_legal;
         (winCfg[w].sizeMask == ptw_pkg::MASK_4GB) |=> maskLegal[w];
      endproperty
      a_mask_4gb_legal: assert property (p_mask_4gb_legal)
         else $error("4GB mask reported illegal");
   end

endmodule // ptw_window_decode

/* tb/ptw_pci_master.sv */
// pci dma master model that presents one address request at a time
`timescale 1ns/1ps
module ptw_pci_master (
   input wire logic clk_sys,
   output ptw_pkg::ptw_req_t req
);
   initial begin
      req = '0;
   end
   // ***************************
   // request issue
   // ***************************
   // released lines show the inverse of the last address, never a stale copy
   task automatic issue(input logic [63:0] addr);
      @(posedge clk_sys);
      #1;
      req.valid = 1'b1;
      req.dac = |addr[63:32];
      req.addr = addr;
      @(posedge clk_sys);
      #1;
      req = '{1'b0, ~req.dac, ~req.addr};
   endtask
endmodule // ptw_pci_master

/* tb/ptw_window_decode_tb_top.sv */
// self-checking bench for the target window decode
`timescale 1ns/1ps
module ptw_window_decode_tb_top;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   ptw_pkg::ptw_win_cfg_t [ptw_pkg::NUM_WIN-1:0] winCfg = '0;
   logic [7:0] dacBase = 8'h00;
   logic passEnable = 1'b0;
   ptw_pkg::ptw_req_t req;
   ptw_pkg::ptw_result_t result;
   logic [ptw_pkg::NUM_WIN-1:0] maskLegal;
   int n_fail = 0;
   int checks = 0;

   always #2.5 clk_sys = ~clk_sys;

   ptw_window_decode DUT (.clk_sys(clk_sys), .reset(reset), .winCfg(winCfg),
      .dacBase(dacBase), .passEnable(passEnable), .req(req), .result(result),
      .maskLegal(maskLegal));
   ptw_pci_master pm (.clk_sys(clk_sys), .req(req));

   // ***************************
   // shared tasks
   // ***************************
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // result is looked at in its one cycle, then must fall back to zero
   task automatic probe(input logic [63:0] a, input logic [38:0] e);
      pm.issue(a);
      check(64'(result), 64'(e));
      @(posedge clk_sys);
      #1;
      check(64'(result), 64'h0);
   endtask

   task automatic report_and_stop();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ***************************
   // scenarios
   // ***************************
   task automatic t_masks();
      logic [11:0] m;
      logic [63:0] a;
      logic [63:0] low;
      for (int k = 0; k <= 12; k++) begin
         m = 12'((13'h1 << k) - 13'h1);
         low = (64'h1 << (20 + k)) - 64'h1;
         winCfg[0] = '{1'b1, 1'b0, 1'b0, 12'h800 & ~m, m, 14'h3000};
         a = {32'h0, 12'h800 & ~m, 20'h0} | low;
         probe(a, {1'b1, 3'h0, 1'b0, 34'h3_0000_0000 | 34'(a & low)});
         if (k < 12) begin
            probe(a ^ (64'h1 << (20 + k)), 39'h0);
         end
         check(64'(maskLegal[0]), 64'h1);
      end
      winCfg[2].sizeMask = 12'h005;
      @(posedge clk_sys);
      #1;
      check(64'(maskLegal[2]), 64'h0);
      winCfg = '0;
      $display("test masks done");
   endtask

   task automatic t_enable_sg();
      winCfg[1] = '{1'b1, 1'b1, 1'b0, 12'h100, 12'h00f, 14'h0123};
      probe(64'h1050_0004, {1'b1, 3'h1, 1'b1, 34'h0_1230_0000});
      check(64'(maskLegal), 64'hf);
      winCfg[1].enable = 1'b0;
      probe(64'h1050_0004, 39'h0);
      winCfg = '0;
      $display("test enable and sg done");
   endtask

   task automatic t_dac();
      dacBase = 8'h5a;
      winCfg[3] = '{1'b1, 1'b0, 1'b1, 12'h200, 12'h000, 14'h0001};
      winCfg[0] = '{1'b1, 1'b0, 1'b0, 12'h200, 12'h000, 14'h0002};
      probe(64'h5a_2000_0010, {1'b1, 3'h3, 1'b0, 34'h0_0010_0010});
      probe(64'h15a_2000_0010, 39'h0);
      probe(64'h5b_2000_0010, 39'h0);
      winCfg[0].enable = 1'b0;
      probe(64'h2000_0010, 39'h0);
      winCfg[3].dacEnable = 1'b0;
      probe(64'h2000_0010, {1'b1, 3'h3, 1'b0, 34'h0_0010_0010});
      probe(64'h1_2345_6789, 39'h0);
      passEnable = 1'b1;
      probe(64'h1_2345_6789, {1'b1, 3'h4, 1'b0, 34'h1_2345_6789});
      probe(64'h2_2345_6789, 39'h0);
      $display("test dual address done");
   endtask

   // ***************************
   // main sequence and watchdog
   // ***************************
   initial begin
      repeat (16) @(posedge clk_sys);
      #1;
      check(64'(result), 64'h0);
      check(64'(maskLegal), 64'h0);
      reset = 1'b0;
      t_masks();
      t_enable_sg();
      t_dac();
      report_and_stop();
   end

   initial begin
      repeat (3000) @(posedge clk_sys);
      n_fail++;
      report_and_stop();
   end
endmodule // ptw_window_decode_tb_top
